// file: core/fcs_device.sv
// fcs_device: device end, parses command frames and runs biometric steps
// assumes: external engine for capture/extract/merge/match, finger pin async
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - capture: wait finger, capture, reply result
// - capture timeout expiry returns without capture
// - no timeout: wait forever for finger
// - sleep argument sets finger polling interval
// - decode 0001 capture, 0002 enroll, 0003 identify
// - decode 3004 info, 0005 image, 0006 template
// - decode 0007 wait, 1002 sensor, 4002 storage
// - decode 6001 as baud rate communication
// - enroll start opens session, replies result
// - enroll add merges template, replies count
// - after add wait finger up; host finishes
// - three touches complete one enrollment
// - enroll finish closes, replies count, result
// - image extract after capture, replies result
// - identify matches; identifier only on match
// - finger-up wait replies when lifted
// - finger-down wait low power, no capture
// - host starts finger wait; never self-entered
// - pending wait ignores commands; reset aborts
// - frame: code, count, key/size/payload arguments
// - await-command is default after boot, procedures
module fcs_device #(
  parameter int MS_CYCLES = fcs_pkg::CYC_PER_MS
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  fcs_link_if.dev                link,
  input  wire logic              finger_present,
  output var  logic              wff_mode,
  output var  logic              eng_req,
  output var  fcs_pkg::fcs_eng_e eng_op,
  input  wire logic              eng_done,
  input  wire logic              eng_ok,
  input  wire logic [15:0]       eng_id
);
  import fcs_pkg::*;

  typedef enum {ST_AWAIT, ST_EXEC, ST_WAIT, ST_ENG, ST_REPLY, ST_LIFT} fcs_dst_e;
  typedef enum {F_CMD, F_NARG, F_KEY, F_SIZE, F_PAY} fcs_fld_e;
  typedef enum {OP_CAPTURE, OP_ENROLL, OP_IDENTIFY, OP_INFO, OP_IMAGE, OP_TEMPLATE,
                OP_WAIT, OP_SENSOR, OP_STORAGE, OP_COMM, OP_UNKNOWN} fcs_op_e;

  typedef struct packed {
    fcs_dst_e    st;
    fcs_fld_e    fld;
    logic        hi;
    logic        pf;
    logic [15:0] key;
    logic [15:0] val;
    logic [15:0] left;
    logic [15:0] cmd;
    logic [5:0]  flg;
    logic        has_tmo;
    logic [15:0] tmo;
    logic [15:0] slp;
    logic        w_dn;
    logic        w_cap;
    logic [23:0] tick_cnt;
    logic [15:0] tmo_cnt;
    logic [15:0] poll_cnt;
    logic [2:0]  sync;
    logic        finger;
    logic        in_enr;
    logic [1:0]  remain;
    logic        post_lift;
    logic [15:0] r_res;
    logic [2:0]  r_f;
    logic        r_match;
    logic [15:0] r_id;
    logic [4:0]  b;
    logic        rvalid;
    logic [7:0]  rdata;
    logic        rlast;
    logic        rdy;
    logic        ereq;
    fcs_eng_e    eop;
    logic        wff;
  } fcs_dev_s;

  localparam int FL_START = 0;
  localparam int FL_ADD   = 1;
  localparam int FL_FIN   = 2;
  localparam int FL_UP    = 3;
  localparam int FL_DN    = 4;
  localparam int FL_EXT   = 5;

  fcs_dev_s    s_r;
  fcs_dev_s    s_nxt;
  logic [15:0] w [RSP_WORDS];
  logic [4:0]  nw;

  function automatic fcs_op_e fcs_decode(input logic [15:0] c);
    unique case (c)
      OPC_CAPTURE:  return OP_CAPTURE;
      OPC_ENROLL:   return OP_ENROLL;
      OPC_IDENTIFY: return OP_IDENTIFY;
      OPC_INFO:     return OP_INFO;
      OPC_IMAGE:    return OP_IMAGE;
      OPC_TEMPLATE: return OP_TEMPLATE;
      OPC_WAIT:     return OP_WAIT;
      OPC_SENSOR:   return OP_SENSOR;
      OPC_STORAGE:  return OP_STORAGE;
      OPC_COMM:     return OP_COMM;
      default:      return OP_UNKNOWN;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // response words: code, count, then key/size/value triplets
  // ---------------------------------------------------------------
  always_comb begin
    int k;
    k = 2;
    for (int i = 0; i < RSP_WORDS; i++) begin
      w[i] = '0;
    end
    w[0] = s_r.cmd;
    if (s_r.r_f[0]) begin
      w[k] = K_COUNT;
      w[k+1] = ARG_BYTES;
      w[k+2] = {14'h0000, s_r.remain};
      k = k + 3;
    end
    if (s_r.r_f[1]) begin
      w[k] = K_MATCH;
      w[k+1] = ARG_BYTES;
      w[k+2] = {15'h0000, s_r.r_match};
      k = k + 3;
    end
    if (s_r.r_f[2]) begin
      w[k] = K_TEMPLATE_IDENTIFIER_ARGUMENT;
      w[k+1] = ARG_BYTES;
      w[k+2] = s_r.r_id;
      k = k + 3;
    end
    w[k] = K_RESULT;
    w[k+1] = ARG_BYTES;
    w[k+2] = s_r.r_res;
    k = k + 3;
    w[1] = 16'((k - 2) / 3);
    nw = 5'(k);
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    logic        take;
    logic        tick;
    logic        poll;
    logic        arg_end;
    logic [15:0] v;
    logic        do_rep;
    logic [15:0] rep_res;
    logic [2:0]  rep_f;
    logic        go_eng;
    fcs_eng_e    op;
    s_nxt = s_r;
    s_nxt.ereq = 1'b0;
    do_rep = 1'b0;
    rep_res = RES_OK;
    rep_f = 3'h0;
    go_eng = 1'b0;
    op = ENG_CAPTURE;
    arg_end = 1'b0;
    v = '0;
    s_nxt.sync = {s_r.sync[1:0], finger_present};
    if (s_r.sync[2] == s_r.sync[1]) begin
      s_nxt.finger = s_r.sync[2];
    end
    tick = (s_r.tick_cnt == 24'(MS_CYCLES - 1));
    s_nxt.tick_cnt = tick ? '0 : s_r.tick_cnt + 24'h000001;
    take = link.req_valid && s_r.rdy;
    poll = (s_r.poll_cnt >= s_r.slp);
    unique case (s_r.st)
      ST_AWAIT: if (take) begin
        v = s_r.hi ? {link.req_data, s_r.val[7:0]} : {8'h00, link.req_data};
        s_nxt.hi = ~s_r.hi;
        s_nxt.val = v;
        unique case (s_r.fld)
          F_CMD: if (s_r.hi) begin
            s_nxt.cmd = v;
            s_nxt.fld = F_NARG;
          end else begin
            s_nxt.flg = '0;
            s_nxt.has_tmo = 1'b0;
            s_nxt.slp = '0;
          end
          F_NARG: if (s_r.hi) s_nxt.fld = F_KEY;
          F_KEY: if (s_r.hi) begin
            s_nxt.key = v;
            s_nxt.fld = F_SIZE;
          end
          F_SIZE: if (s_r.hi) begin
            s_nxt.left = v;
            s_nxt.pf = 1'b0;
            s_nxt.val = '0;
            arg_end = (v == '0);
            v = '0;
            s_nxt.fld = arg_end ? F_KEY : F_PAY;
          end
          F_PAY: begin
            s_nxt.hi = 1'b1;
            s_nxt.pf = s_r.hi;
            if (s_r.hi && s_r.pf) v = s_r.val;
            s_nxt.val = v;
            s_nxt.left = s_r.left - 16'h0001;
            if (s_r.left == 16'h0001) begin
              arg_end = 1'b1;
              s_nxt.hi = 1'b0;
              s_nxt.fld = F_KEY;
            end
          end
        endcase
        if (link.req_last) s_nxt.st = ST_EXEC;
      end
      ST_EXEC: begin
        s_nxt.fld = F_CMD;
        s_nxt.hi = 1'b0;
        s_nxt.tmo_cnt = '0;
        s_nxt.poll_cnt = '0;
        unique case (fcs_decode(s_r.cmd))
          OP_CAPTURE: begin
            s_nxt.st = ST_WAIT;
            s_nxt.w_dn = 1'b1;
            s_nxt.w_cap = 1'b1;
          end
          OP_WAIT: if (s_r.flg[FL_UP] || s_r.flg[FL_DN]) begin
            s_nxt.st = ST_WAIT;
            s_nxt.w_dn = s_r.flg[FL_DN];
            s_nxt.w_cap = 1'b0;
          end else begin
            do_rep = 1'b1;
            rep_res = RES_BAD_STATE;
          end
          OP_ENROLL: begin
            go_eng = 1'b1;
            if (s_r.flg[FL_START]) op = ENG_ENR_INIT;
            else if (s_r.flg[FL_ADD] && s_r.in_enr && s_r.remain != 2'h0) op = ENG_ENR_ADD;
            else if (s_r.flg[FL_FIN] && s_r.in_enr) op = ENG_ENR_CLOSE;
            else begin
              go_eng = 1'b0;
              do_rep = 1'b1;
              rep_res = RES_BAD_STATE;
            end
          end
          OP_IMAGE: if (s_r.flg[FL_EXT]) begin
            go_eng = 1'b1;
            op = ENG_EXTRACT;
          end else begin
            do_rep = 1'b1;
            rep_res = RES_UNSUPPORTED;
          end
          OP_IDENTIFY: begin
            go_eng = 1'b1;
            op = ENG_MATCH;
          end
          OP_INFO, OP_TEMPLATE, OP_SENSOR, OP_STORAGE, OP_COMM, OP_UNKNOWN: begin
            do_rep = 1'b1;
            rep_res = RES_UNSUPPORTED;
          end
        endcase
      end
      ST_WAIT: begin
        if (tick) begin
          s_nxt.tmo_cnt = s_r.tmo_cnt + 16'h0001;
          s_nxt.poll_cnt = poll ? 16'h0000 : s_r.poll_cnt + 16'h0001;
        end
        if (poll && s_r.finger == s_r.w_dn) begin
          if (s_r.w_cap) begin
            go_eng = 1'b1;
            op = ENG_CAPTURE;
          end else begin
            do_rep = 1'b1;
          end
        end else if (s_r.has_tmo && s_r.tmo_cnt >= s_r.tmo) begin
          do_rep = 1'b1;
          rep_res = RES_TIMEOUT;
        end
      end
      ST_ENG: if (eng_done) begin
        do_rep = 1'b1;
        rep_res = eng_ok ? RES_OK : RES_FAIL;
        unique case (s_r.eop)
          ENG_CAPTURE, ENG_EXTRACT: ;
          ENG_ENR_INIT: begin
            s_nxt.in_enr = eng_ok;
            s_nxt.remain = ENROLL_TOUCHES;
          end
          ENG_ENR_ADD: begin
            if (eng_ok) s_nxt.remain = s_r.remain - 2'h1;
            rep_f = 3'h1;
            s_nxt.post_lift = 1'b1;
          end
          ENG_ENR_CLOSE: begin
            s_nxt.in_enr = 1'b0;
            rep_f = 3'h1;
            if (s_r.remain != 2'h0) rep_res = RES_FAIL;
          end
          ENG_MATCH: begin
            s_nxt.r_match = eng_ok;
            s_nxt.r_id = eng_id;
            rep_f = {eng_ok, 2'h2};
            rep_res = RES_OK;
          end
        endcase
      end
      ST_REPLY: if (!s_r.rvalid || link.rsp_ready) begin
        if (s_r.rvalid && s_r.rlast) begin
          s_nxt.rvalid = 1'b0;
          s_nxt.rlast = 1'b0;
          s_nxt.post_lift = 1'b0;
          s_nxt.st = s_r.post_lift ? ST_LIFT : ST_AWAIT;
        end else begin
          s_nxt.rvalid = 1'b1;
          s_nxt.rdata = s_r.b[0] ? w[s_r.b[4:1]][15:8] : w[s_r.b[4:1]][7:0];
          s_nxt.rlast = (s_r.b == 5'({nw, 1'b0} - 6'h01));
          s_nxt.b = s_r.b + 5'h01;
        end
      end
      ST_LIFT: if (!s_r.finger) s_nxt.st = ST_AWAIT;
    endcase
    if (arg_end) begin
      case (s_r.key)
        K_TIMEOUT: begin
          s_nxt.has_tmo = 1'b1;
          s_nxt.tmo = v;
        end
        K_SLEEP:   s_nxt.slp = v;
        K_START:   s_nxt.flg[FL_START] = 1'b1;
        K_ADD:     s_nxt.flg[FL_ADD] = 1'b1;
        K_FINISH:  s_nxt.flg[FL_FIN] = 1'b1;
        K_FUP:     s_nxt.flg[FL_UP] = 1'b1;
        K_FDOWN:   s_nxt.flg[FL_DN] = 1'b1;
        K_EXTRACT: s_nxt.flg[FL_EXT] = 1'b1;
        default:   ;
      endcase
    end
    if (go_eng) begin
      s_nxt.st = ST_ENG;
      s_nxt.ereq = 1'b1;
      s_nxt.eop = op;
    end
    if (do_rep) begin
      s_nxt.st = ST_REPLY;
      s_nxt.r_res = rep_res;
      s_nxt.r_f = rep_f;
      s_nxt.b = '0;
    end
    s_nxt.rdy = (s_nxt.st == ST_AWAIT) || (s_nxt.st == ST_WAIT);
    s_nxt.wff = (s_nxt.st == ST_WAIT) && s_nxt.w_dn;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.req_ready = s_r.rdy;
  assign link.rsp_valid = s_r.rvalid;
  assign link.rsp_data  = s_r.rdata;
  assign link.rsp_last  = s_r.rlast;
  assign wff_mode       = s_r.wff;
  assign eng_req        = s_r.ereq;
  assign eng_op         = s_r.eop;

endmodule
`default_nettype wire

// file: core/fcs_host.sv
// fcs_host: host end, sends one command frame and collects its reply
// assumes: device answers every frame with 2-byte argument payloads
`timescale 1ns/1ps
`default_nettype none
module fcs_host (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  fcs_link_if.host               link,
  input  wire logic              cmd_valid,
  output var  logic              cmd_ready,
  input  wire logic [15:0]       cmd_code,
  input  wire logic [1:0]        cmd_nargs,
  input  wire logic [2:0][15:0]  cmd_key,
  input  wire logic [2:0]        cmd_has_val,
  input  wire logic [2:0][15:0]  cmd_val,
  output var  logic              rep_valid,
  output var  logic [15:0]       rep_cmd,
  output var  logic              rep_paired,
  output var  logic [15:0]       rep_result,
  output var  logic [15:0]       rep_count,
  output var  logic              rep_match,
  output var  logic [15:0]       rep_id,
  output var  logic              rep_has_id
);
  import fcs_pkg::*;

  typedef enum {H_IDLE, H_SEND, H_RECV} fcs_hst_e;

  typedef struct packed {
    fcs_hst_e         st;
    logic [15:0]      code;
    logic [1:0]       nargs;
    logic [2:0][15:0] key;
    logic [2:0]       hv;
    logic [2:0][15:0] val;
    logic [4:0]       b;
    logic             tvalid;
    logic [7:0]       tdata;
    logic             tlast;
    logic             hi;
    logic [7:0]       lo;
    logic [4:0]       wi;
    logic [1:0]       ph;
    logic [15:0]      ckey;
    logic             rrdy;
    logic             cready;
    logic             rv;
    logic [15:0]      rcmd;
    logic             paired;
    logic [15:0]      res;
    logic [15:0]      cnt;
    logic             match;
    logic [15:0]      id;
    logic             has_id;
  } fcs_host_s;

  fcs_host_s   s_r;
  fcs_host_s   s_nxt;
  logic [15:0] w [RSP_WORDS];
  logic [4:0]  nw;

  // ---------------------------------------------------------------
  // request words from the latched command
  // ---------------------------------------------------------------
  always_comb begin
    int k;
    k = 2;
    for (int i = 0; i < RSP_WORDS; i++) begin
      w[i] = '0;
    end
    w[0] = s_r.code;
    w[1] = {14'h0000, s_r.nargs};
    for (int i = 0; i < 3; i++) begin
      if (i < int'(s_r.nargs)) begin
        w[k] = s_r.key[i];
        w[k+1] = s_r.hv[i] ? ARG_BYTES : 16'h0000;
        w[k+2] = s_r.val[i];
        k = k + (s_r.hv[i] ? 3 : 2);
      end
    end
    nw = 5'(k);
  end

  // ---------------------------------------------------------------
  // send, then receive exactly one reply
  // ---------------------------------------------------------------
  always_comb begin
    logic [15:0] v;
    s_nxt = s_r;
    s_nxt.rv = 1'b0;
    s_nxt.rrdy = 1'b1;
    v = {link.rsp_data, s_r.lo};
    unique case (s_r.st)
      H_IDLE: if (cmd_valid && s_r.cready) begin
        s_nxt.st = H_SEND;
        s_nxt.code = cmd_code;
        s_nxt.nargs = cmd_nargs;
        s_nxt.key = cmd_key;
        s_nxt.hv = cmd_has_val;
        s_nxt.val = cmd_val;
        s_nxt.b = '0;
        s_nxt.hi = 1'b0;
        s_nxt.wi = '0;
        s_nxt.ph = '0;
        s_nxt.has_id = 1'b0;
        s_nxt.match = 1'b0;
      end
      H_SEND: if (!s_r.tvalid || link.req_ready) begin
        if (s_r.tvalid && s_r.tlast) begin
          s_nxt.tvalid = 1'b0;
          s_nxt.tlast = 1'b0;
          s_nxt.st = H_RECV;
        end else begin
          s_nxt.tvalid = 1'b1;
          s_nxt.tdata = s_r.b[0] ? w[s_r.b[4:1]][15:8] : w[s_r.b[4:1]][7:0];
          s_nxt.tlast = (s_r.b == 5'({nw, 1'b0} - 6'h01));
          s_nxt.b = s_r.b + 5'h01;
        end
      end
      H_RECV: if (link.rsp_valid && s_r.rrdy) begin
        s_nxt.hi = ~s_r.hi;
        s_nxt.lo = link.rsp_data;
        if (s_r.hi) begin
          s_nxt.wi = s_r.wi + 5'h01;
          if (s_r.wi == 5'h00) s_nxt.rcmd = v;
          else if (s_r.wi != 5'h01) begin
            s_nxt.ph = (s_r.ph == 2'h2) ? 2'h0 : s_r.ph + 2'h1;
            if (s_r.ph == 2'h0) s_nxt.ckey = v;
            if (s_r.ph == 2'h2) begin
              case (s_r.ckey)
                K_RESULT: s_nxt.res = v;
                K_COUNT:  s_nxt.cnt = v;
                K_MATCH:  s_nxt.match = v[0];
                K_TEMPLATE_IDENTIFIER_ARGUMENT: begin
                  s_nxt.id = v;
                  s_nxt.has_id = 1'b1;
                end
                default: ;
              endcase
            end
          end
        end
        if (link.rsp_last) begin
          s_nxt.st = H_IDLE;
          s_nxt.rv = 1'b1;
          s_nxt.paired = (s_nxt.rcmd == s_r.code);
        end
      end
    endcase
    s_nxt.cready = (s_nxt.st == H_IDLE);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.req_valid = s_r.tvalid;
  assign link.req_data  = s_r.tdata;
  assign link.req_last  = s_r.tlast;
  assign link.rsp_ready = s_r.rrdy;
  assign cmd_ready      = s_r.cready;
  assign rep_valid      = s_r.rv;
  assign rep_cmd        = s_r.rcmd;
  assign rep_paired     = s_r.paired;
  assign rep_result     = s_r.res;
  assign rep_count      = s_r.cnt;
  assign rep_match      = s_r.match;
  assign rep_id         = s_r.id;
  assign rep_has_id     = s_r.has_id;

endmodule
`default_nettype wire

// file: include/fcs_link_if.sv
// fcs_link_if: byte link carrying command and response frames
// assumes: both ends share ref_clk; valid/ready handshake per byte
`timescale 1ns/1ps
`default_nettype none
interface fcs_link_if;
  logic       req_valid;
  logic       req_ready;
  logic [7:0] req_data;
  logic       req_last;
  logic       rsp_valid;
  logic       rsp_ready;
  logic [7:0] rsp_data;
  logic       rsp_last;

  modport dev  (input  req_valid, req_data, req_last, rsp_ready,
                output req_ready, rsp_valid, rsp_data, rsp_last);
  modport host (output req_valid, req_data, req_last, rsp_ready,
                input  req_ready, rsp_valid, rsp_data, rsp_last);
endinterface
`default_nettype wire

// file: include/fcs_pkg.sv
// fcs_pkg: constants and types shared by both ends of the command sequencer
// assumes: 10 MHz ref_clk, little-endian 16-bit fields on a byte link
package fcs_pkg;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [15:0] OPC_CAPTURE  = 16'h0001;
  localparam logic [15:0] OPC_ENROLL   = 16'h0002;
  localparam logic [15:0] OPC_IDENTIFY = 16'h0003;
  localparam logic [15:0] OPC_INFO     = 16'h3004;
  localparam logic [15:0] OPC_IMAGE    = 16'h0005;
  localparam logic [15:0] OPC_TEMPLATE = 16'h0006;
  localparam logic [15:0] OPC_WAIT     = 16'h0007;
  localparam logic [15:0] OPC_SENSOR   = 16'h1002;
  localparam logic [15:0] OPC_STORAGE  = 16'h4002;
  localparam logic [15:0] OPC_COMM     = 16'h6001;

  // ---------------------------------------------------------------
  // argument keys
  // ---------------------------------------------------------------
  localparam logic [15:0] K_TIMEOUT = 16'h0001;
  localparam logic [15:0] K_SLEEP   = 16'h0002;
  localparam logic [15:0] K_START   = 16'h0003;
  localparam logic [15:0] K_ADD     = 16'h0004;
  localparam logic [15:0] K_FINISH  = 16'h0005;
  localparam logic [15:0] K_FUP     = 16'h0006;
  localparam logic [15:0] K_FDOWN   = 16'h0007;
  localparam logic [15:0] K_EXTRACT = 16'h0008;
  localparam logic [15:0] K_RESULT  = 16'h0009;
  localparam logic [15:0] K_COUNT   = 16'h000a;
  localparam logic [15:0] K_MATCH   = 16'h000b;
  localparam logic [15:0] K_TEMPLATE_IDENTIFIER_ARGUMENT = 16'h000c;
  localparam logic [15:0] ARG_BYTES = 16'h0002;

  // ---------------------------------------------------------------
  // result codes
  // ---------------------------------------------------------------
  localparam logic [15:0] RES_OK          = 16'h0000;
  localparam logic [15:0] RES_TIMEOUT     = 16'h0001;
  localparam logic [15:0] RES_FAIL        = 16'h0002;
  localparam logic [15:0] RES_BAD_STATE   = 16'h0003;
  localparam logic [15:0] RES_UNSUPPORTED = 16'h0004;

  // ---------------------------------------------------------------
  // counts and timing
  // ---------------------------------------------------------------
  localparam logic [1:0] ENROLL_TOUCHES = 2'h3;
  localparam int RSP_WORDS  = 14;
  localparam int CLK_NS     = 100;
  localparam int MS_NS      = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_NS;

  typedef enum {ENG_CAPTURE, ENG_EXTRACT, ENG_ENR_INIT, ENG_ENR_ADD,
                ENG_ENR_CLOSE, ENG_MATCH} fcs_eng_e;

endpackage

// file: tb/fcs_props.sv
// fcs_props: wire checks on the byte link
// assumes: instantiated beside the link interface
`timescale 1ns/1ps
`default_nettype none
module fcs_props (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic [7:0] req_data,
  input wire logic       req_last,
  input wire logic       rsp_valid,
  input wire logic       rsp_ready,
  input wire logic [7:0] rsp_data,
  input wire logic       rsp_last
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic pend_r;
  logic pend_nxt;
  wire logic tk_req = req_valid && req_ready && req_last;
  wire logic tk_rsp = rsp_valid && rsp_ready && rsp_last;
  always_comb pend_nxt = tk_req ? 1'b1 : (tk_rsp ? 1'b0 : pend_r);
  always_ff @(posedge ref_clk) pend_r <= rst_n ? pend_nxt : 1'b0;
  // ----
  // properties
  // ----
  property p_hold; req_valid && !req_ready |=> req_valid && $stable(req_data); endproperty
  property p_len; $rose(rsp_valid) |-> (rsp_valid && !rsp_last)[*8]; endproperty
  property p_fmt;
    $rose(rsp_valid) |-> ##3 rsp_data == 8'h00 ##2 rsp_data == 8'h00
      ##1 rsp_data == 8'h02 ##1 rsp_data == 8'h00;
  endproperty
  property p_busy; rsp_valid |-> !req_ready; endproperty
  property p_last; rsp_last |-> rsp_valid; endproperty
  property p_done; tk_rsp |=> !rsp_valid; endproperty
  property p_pend; rsp_valid |-> pend_r; endproperty
  property p_gap; tk_req |=> !rsp_valid; endproperty
  a_hold: assert property (p_hold) else $error("request byte dropped");
  a_len: assert property (p_len) else $error("reply too short");
  a_fmt: assert property (p_fmt) else $error("reply field bytes wrong");
  a_busy: assert property (p_busy) else $error("request taken while replying");
  a_last: assert property (p_last) else $error("last without valid");
  a_done: assert property (p_done) else $error("reply runs past last");
  a_pend: assert property (p_pend) else $error("reply without request");
  a_gap: assert property (p_gap) else $error("reply too early");
  c_rsp: cover property ($rose(rsp_valid));
  c_stall: cover property (req_valid && !req_ready);
  c_end: cover property (tk_rsp);
endmodule
`default_nettype wire

// file: tb/fcs_test.sv
// fcs_test: host end drives the device end; engine modelled here
// assumes: both ends joined by fcs_link_if
`timescale 1ns/1ps
`default_nettype none
module fcs_test;
  import fcs_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, finger = 1'b0, eng_done = 1'b0, eng_ok = 1'b1;
  logic cmd_valid = 1'b0, eng_req, wff_mode, cmd_ready, rep_valid, rep_paired;
  logic rep_match, rep_has_id;
  logic [15:0] eng_id = 16'h0042, cmd_code = 16'h0000, rep_cmd, rep_result, rep_count, rep_id;
  logic [1:0] cmd_nargs = 2'h0;
  logic [2:0] cmd_has_val = 3'h0;
  logic [2:0][15:0] cmd_key = 48'h0, cmd_val = 48'h0;
  fcs_eng_e eng_op;
  int err_count = 0, check_count = 0, cyc = 0, eng_cnt = 0, e0;
  fcs_link_if lk();
  fcs_device #(.MS_CYCLES(10)) fcs_device_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(lk),
    .finger_present(finger), .wff_mode(wff_mode), .eng_req(eng_req), .eng_op(eng_op),
    .eng_done(eng_done), .eng_ok(eng_ok), .eng_id(eng_id));
  fcs_host fcs_host_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(lk), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_nargs(cmd_nargs), .cmd_key(cmd_key),
    .cmd_has_val(cmd_has_val), .cmd_val(cmd_val), .rep_valid(rep_valid), .rep_cmd(rep_cmd),
    .rep_paired(rep_paired), .rep_result(rep_result), .rep_count(rep_count),
    .rep_match(rep_match), .rep_id(rep_id), .rep_has_id(rep_has_id));
  fcs_props fcs_props_inst (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(lk.req_valid),
    .req_ready(lk.req_ready), .req_data(lk.req_data), .req_last(lk.req_last),
    .rsp_valid(lk.rsp_valid), .rsp_ready(lk.rsp_ready), .rsp_data(lk.rsp_data),
    .rsp_last(lk.rsp_last));
  // ----
  // clock, engine, watchdog
  // ----
  always #50 ref_clk = ~ref_clk;
  always @(negedge ref_clk) eng_done = eng_req;
  always @(posedge ref_clk) begin
    cyc++;
    if (eng_req === 1'b1) eng_cnt++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  task chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task cmd(input logic [15:0] c, input logic [1:0] n, input logic [15:0] k, input logic h,
           input logic [15:0] v, input int lim);
    int i;
    logic [7:0] b0;
    logic seen;
    seen = 1'b0;
    while (cmd_ready !== 1'b1) @(negedge ref_clk);
    cmd_code = c;
    cmd_nargs = n;
    cmd_key = {32'h0, k};
    cmd_has_val = {2'h0, h};
    cmd_val = {32'h0, v};
    cmd_valid = 1'b1;
    @(negedge ref_clk) cmd_valid = 1'b0;
    for (i = 0; i < lim && rep_valid !== 1'b1; i++) begin
      @(negedge ref_clk);
      if (lk.rsp_valid === 1'b1 && !seen) begin
        seen = 1'b1;
        b0 = lk.rsp_data;
      end
    end
    if (lim > 100) begin
      chk({15'h0, rep_paired}, 16'h1);
      chk(rep_cmd, c);
      chk({8'h0, b0}, {8'h0, c[7:0]});
    end else chk(i[15:0], lim[15:0]);
  endtask
  // ----
  // scenarios
  // ----
  task t_decode;
    static logic [15:0] ops [5] = '{OPC_INFO, OPC_TEMPLATE, OPC_SENSOR, OPC_STORAGE, OPC_COMM};
    foreach (ops[i]) begin
      cmd(ops[i], 2'h0, 16'h0, 1'b0, 16'h0, 4000);
      chk(rep_result, RES_UNSUPPORTED);
    end
    $display("t_decode done");
  endtask
  task t_ident;
    finger = 1'b1;
    repeat (5) @(negedge ref_clk);
    e0 = eng_cnt;
    cmd(OPC_CAPTURE, 2'h0, 16'h0, 1'b0, 16'h0, 4000);
    chk(rep_result, RES_OK);
    chk(16'(eng_cnt - e0), 16'h1);
    cmd(OPC_IMAGE, 2'h1, K_EXTRACT, 1'b0, 16'h0, 4000);
    chk(rep_result, RES_OK);
    cmd(OPC_IDENTIFY, 2'h0, 16'h0, 1'b0, 16'h0, 4000);
    chk({14'h0, rep_match, rep_has_id}, 16'h3);
    chk(rep_id, 16'h0042);
    chk(16'(eng_op), 16'(ENG_MATCH));
    eng_ok = 1'b0;
    cmd(OPC_IDENTIFY, 2'h0, 16'h0, 1'b0, 16'h0, 4000);
    chk({14'h0, rep_match, rep_has_id}, 16'h0);
    eng_ok = 1'b1;
    e0 = cyc;
    cmd(OPC_CAPTURE, 2'h1, K_SLEEP, 1'b1, 16'h0003, 4000);
    chk({15'h0, cyc - e0 > 40}, 16'h1);
    $display("t_ident done");
  endtask
  task t_timeout;
    finger = 1'b0;
    repeat (5) @(negedge ref_clk);
    e0 = eng_cnt;
    cmd(OPC_CAPTURE, 2'h1, K_TIMEOUT, 1'b1, 16'h0002, 4000);
    chk(rep_result, RES_TIMEOUT);
    chk(16'(eng_cnt - e0), 16'h0);
    $display("t_timeout done");
  endtask
  task t_enroll;
    cmd(OPC_ENROLL, 2'h1, K_START, 1'b0, 16'h0, 4000);
    chk(rep_result, RES_OK);
    for (int j = 0; j < 3; j++) begin
      finger = (j == 2);
      cmd(OPC_ENROLL, 2'h1, K_ADD, 1'b0, 16'h0, 4000);
      chk(rep_count, 16'h2 - j[15:0]);
    end
    cmd(OPC_ENROLL, 2'h1, K_FINISH, 1'b0, 16'h0, 60);
    finger = 1'b0;
    while (rep_valid !== 1'b1) @(negedge ref_clk);
    chk(rep_count, 16'h0);
    chk(rep_result, RES_OK);
    chk(rep_cmd, OPC_ENROLL);
    $display("t_enroll done");
  endtask
  task t_wait;
    finger = 1'b1;
    repeat (5) @(negedge ref_clk);
    e0 = eng_cnt;
    cmd(OPC_WAIT, 2'h1, K_FDOWN, 1'b0, 16'h0, 4000);
    chk(rep_result, RES_OK);
    chk(16'(eng_cnt - e0), 16'h0);
    finger = 1'b0;
    cmd(OPC_WAIT, 2'h1, K_FUP, 1'b0, 16'h0, 4000);
    chk(rep_result, RES_OK);
    cmd(OPC_WAIT, 2'h1, K_FDOWN, 1'b0, 16'h0, 50);
    chk({15'h0, wff_mode}, 16'h1);
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (5) @(negedge ref_clk);
    cmd(OPC_INFO, 2'h0, 16'h0, 1'b0, 16'h0, 4000);
    chk(rep_result, RES_UNSUPPORTED);
    $display("t_wait done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_decode();
    t_ident();
    t_timeout();
    t_enroll();
    t_wait();
    wrap_up();
  end
endmodule
`default_nettype wire
